// ==== shared/adc_cfg.svh ====
// register offsets, field positions, reset values and timing for the converter control
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH

`define ADC_IDX_CTRL1      8'h1C
`define ADC_IDX_CTRL2      8'h1D
`define ADC_IDX_RES_LOW    8'h1E
`define ADC_IDX_RES_HIGH   8'h1F

`define ADC_CTRL1_RESET    8'h10
`define ADC_CTRL2_RESET    8'h00
`define ADC_START_BIT      7
`define ADC_MODE_HI        6
`define ADC_MODE_LO        5
`define ADC_AIN_DIS_BIT    4
`define ADC_CHAN_HI        3
`define ADC_LADDER_BIT     5
`define ADC_CTIME_HI       3
`define ADC_CTIME_LO       1

`define ADC_TICKS_000      11'h027
`define ADC_TICKS_010      11'h04E
`define ADC_TICKS_011      11'h09C
`define ADC_TICKS_100      11'h138
`define ADC_TICKS_101      11'h270
`define ADC_TICKS_110      11'h4E0
`define ADC_SAMPLE_STEPS   4'h2
`define ADC_MSB_TRIAL      10'h200

`endif

// ==== shared/adc_pkg.sv ====
// types used by the converter control for its mode field and sequencer state
package adc_pkg;
  typedef enum logic [1:0] {
    MODE_OFF    = 2'h0,
    MODE_SOFT   = 2'h1,
    MODE_RSVD   = 2'h2,
    MODE_REPEAT = 2'h3
  } op_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h1,
    ST_SAMPLE  = 3'h2,
    ST_CONVERT = 3'h4
  } conv_state_t;
endpackage : adc_pkg

// ==== design/conv_timer.sv ====
// conversion length counter in oscillator ticks, with evenly spaced step pulses
`timescale 1ns/1ns
module conv_timer #(
  parameter int TW = 11
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  // control
  input  wire logic          fc_tick,
  input  wire logic          load,
  input  wire logic          abort,
  input  wire logic [TW-1:0] ticks,
  // events
  output logic               step,
  output logic               done
);
  logic [TW-1:0] count_r;
  logic [TW-1:0] step_cnt_r;
  logic [TW-1:0] period_r;
  logic          run_r;

  // a step every sixteenth of the length, rounded down, leaves room for sample plus ten trials
  always_comb begin
    done = run_r && fc_tick && (count_r == TW'(1));
    step = run_r && fc_tick && (step_cnt_r == TW'(1)) && !done;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_r    <= '0;
      step_cnt_r <= '0;
      period_r   <= '0;
      run_r      <= 1'b0;
    end else if (abort) begin
      run_r <= 1'b0;
    end else if (load) begin
      count_r    <= ticks;
      period_r   <= ticks >> 4;
      step_cnt_r <= ticks >> 4;
      run_r      <= 1'b1;
    end else if (run_r && fc_tick) begin
      count_r    <= count_r - TW'(1);
      step_cnt_r <= (step_cnt_r == TW'(1)) ? period_r : step_cnt_r - TW'(1);
      if (done)
        run_r <= 1'b0;
    end
  end
endmodule : conv_timer

// ==== design/sar_adc_ctrl.sv ====
// successive-approximation converter control with apb register slave
//
// Contract
// - ladder connects during conversion or when forced
// - time code picks 39 to 1248 ticks
// - second control bits 7:6 read undefined
// - standby resets control, blocks its writes
// - result split high eight, low two
// - high result read clears done flag
// - busy set at start, cleared at end
// - low result bits 3:0 read arbitrary
// - start bit in soft mode converts once
// - completion stores result, flags, interrupts together
// - start bit self-clears once conversion begins
// - repeat mode restarts after each completion
// - mode off aborts, partial result discarded
// - new start clears flag, keeps old result
// - mode field: off, soft, reserved, repeat
// - channel field selects inputs zero to seven
// - analog input disable bit gates inputs
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
`include "adc_cfg.svh"
module sar_adc_ctrl #(
  parameter int AW     = 8,
  // below 3 a trial acts on a stale synchronised comparator at the shortest time code
  parameter int FC_DIV = 16
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  // power manager
  input  wire logic          standby_req,
  // analog front end
  input  wire logic          comparator_in,
  output logic [3:0]         channel_select_field,
  output logic               analog_input_disable,
  output logic               ladder_connect,
  output logic               sample_hold,
  output logic [9:0]         dac_code,
  // completion event
  output logic               conversion_done_irq
);
  localparam int TW = 11;

  logic [7:0]  ctrl1_r;
  logic [7:0]  ctrl2_r;
  logic [9:0]  result_r;
  logic        done_flag_r;
  logic        busy_r;
  adc_pkg::conv_state_t state_r;
  logic [9:0]  sar_r;
  logic [9:0]  trial_r;
  logic [3:0]  step_idx_r;
  logic [7:0]  fc_div_r;
  logic        fc_tick;
  logic        comp_meta_r;
  logic        comp_s2_r;
  logic        comp_s3_r;
  logic        comp_r;
  logic        wr_acc;
  logic        rd_acc;
  logic        start_req;
  logic        restart;
  logic        mode_kill;
  logic        conv_go;
  logic        step;
  logic        conv_done;
  logic [TW-1:0] ticks_sel;
  adc_pkg::op_mode_t mode;
  adc_pkg::op_mode_t wr_mode;

  function automatic logic [AW-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = AW'({idx, 2'b00});
  endfunction : byte_addr

  function automatic logic mode_runs(input adc_pkg::op_mode_t m);
    mode_runs = (m == adc_pkg::MODE_SOFT) || (m == adc_pkg::MODE_REPEAT);
  endfunction : mode_runs

  // reserved codes fall back to the nearest legal length
  function automatic logic [TW-1:0] ticks_for(input logic [2:0] code);
    unique case (code)
      3'h0, 3'h1: ticks_for = `ADC_TICKS_000;
      3'h2:       ticks_for = `ADC_TICKS_010;
      3'h3:       ticks_for = `ADC_TICKS_011;
      3'h4:       ticks_for = `ADC_TICKS_100;
      3'h5:       ticks_for = `ADC_TICKS_101;
      default:    ticks_for = `ADC_TICKS_110;
    endcase
  endfunction : ticks_for

  always_comb begin
    mode      = adc_pkg::op_mode_t'(ctrl1_r[`ADC_MODE_HI:`ADC_MODE_LO]);
    wr_mode   = adc_pkg::op_mode_t'(pwdata[`ADC_MODE_HI:`ADC_MODE_LO]);
    ticks_sel = ticks_for(ctrl2_r[`ADC_CTIME_HI:`ADC_CTIME_LO]);
    wr_acc    = psel && penable && pwrite && !standby_req;
    rd_acc    = psel && penable && !pwrite;
    mode_kill = !mode_runs(mode) && busy_r;
    start_req = ctrl1_r[`ADC_START_BIT] && mode_runs(mode) && !busy_r
                && !standby_req;
    restart   = conv_done && (mode == adc_pkg::MODE_REPEAT)
                && !standby_req;
    conv_go   = start_req || restart;
  end

  // oscillator tick enable derived from the system clock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      fc_div_r <= '0;
    else if (fc_div_r == 8'(FC_DIV - 1))
      fc_div_r <= '0;
    else
      fc_div_r <= fc_div_r + 8'h01;
  end
  assign fc_tick = (fc_div_r == 8'(FC_DIV - 1));

  // comparator is asynchronous to us; accept only once two stages agree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      comp_meta_r <= 1'b0;
      comp_s2_r   <= 1'b0;
      comp_s3_r   <= 1'b0;
      comp_r      <= 1'b0;
    end else begin
      comp_meta_r <= comparator_in;
      comp_s2_r   <= comp_meta_r;
      comp_s3_r   <= comp_s2_r;
      if (comp_s2_r == comp_s3_r)
        comp_r <= comp_s3_r;
    end
  end

  conv_timer #(.TW(TW)) u_timer (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .fc_tick (fc_tick),
    .load    (conv_go),
    .abort   (mode_kill || standby_req),
    .ticks   (ticks_sel),
    .step    (step),
    .done    (conv_done)
  );

  // control registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_r <= `ADC_CTRL1_RESET;
      ctrl2_r <= `ADC_CTRL2_RESET;
    end else if (standby_req) begin
      ctrl1_r <= `ADC_CTRL1_RESET;
      ctrl2_r <= `ADC_CTRL2_RESET;
    end else begin
      if (start_req)
        ctrl1_r[`ADC_START_BIT] <= 1'b0;
      if (wr_acc && paddr == byte_addr(`ADC_IDX_CTRL1))
        ctrl1_r <= pwdata[7:0];
      if (wr_acc && paddr == byte_addr(`ADC_IDX_CTRL2))
        ctrl2_r <= pwdata[7:0];
    end
  end

  // conversion sequencer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= adc_pkg::ST_IDLE;
      busy_r     <= 1'b0;
      sar_r      <= '0;
      trial_r    <= '0;
      step_idx_r <= '0;
    end else if (standby_req || mode_kill) begin
      state_r <= adc_pkg::ST_IDLE;
      busy_r  <= 1'b0;
      trial_r <= '0;
    end else if (conv_go) begin
      state_r    <= adc_pkg::ST_SAMPLE;
      busy_r     <= 1'b1;
      sar_r      <= '0;
      trial_r    <= '0;
      step_idx_r <= '0;
    end else if (conv_done) begin
      state_r <= adc_pkg::ST_IDLE;
      busy_r  <= 1'b0;
    end else if (step) begin
      step_idx_r <= step_idx_r + 4'h1;
      unique case (state_r)
        adc_pkg::ST_SAMPLE: begin
          if (step_idx_r == `ADC_SAMPLE_STEPS - 4'h1) begin
            state_r <= adc_pkg::ST_CONVERT;
            sar_r   <= `ADC_MSB_TRIAL;
            trial_r <= `ADC_MSB_TRIAL;
          end
        end
        adc_pkg::ST_CONVERT: begin
          if (trial_r != '0) begin
            sar_r   <= (comp_r ? sar_r : (sar_r & ~trial_r)) | (trial_r >> 1);
            trial_r <= trial_r >> 1;
          end
        end
        adc_pkg::ST_IDLE: begin
        end
      endcase
    end
  end

  // result and flags; hardware set wins over the read clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      result_r    <= '0;
      done_flag_r <= 1'b0;
    end else if (standby_req) begin
      result_r    <= '0;
      done_flag_r <= 1'b0;
    end else if (conv_done && !mode_kill) begin
      result_r    <= sar_r;
      done_flag_r <= 1'b1;
    end else if (start_req) begin
      done_flag_r <= 1'b0;
    end else if (rd_acc && paddr == byte_addr(`ADC_IDX_RES_HIGH)) begin
      done_flag_r <= 1'b0;
    end
  end

  // analog side controls and completion pulse
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ladder_connect       <= 1'b0;
      sample_hold          <= 1'b0;
      dac_code             <= '0;
      channel_select_field <= '0;
      analog_input_disable <= 1'b1;
      conversion_done_irq  <= 1'b0;
    end else begin
      ladder_connect       <= ctrl2_r[`ADC_LADDER_BIT] || busy_r;
      sample_hold          <= state_r == adc_pkg::ST_SAMPLE;
      dac_code             <= sar_r;
      channel_select_field <= ctrl1_r[`ADC_CHAN_HI:0];
      analog_input_disable <= ctrl1_r[`ADC_AIN_DIS_BIT];
      conversion_done_irq  <= conv_done && !standby_req && !mode_kill;
    end
  end

  // apb: zero wait states, read data prepared during setup
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        pslverr <= 1'b0;
        prdata  <= '0;
        unique case (paddr)
          byte_addr(`ADC_IDX_CTRL1):    prdata[7:0] <= ctrl1_r;
          byte_addr(`ADC_IDX_CTRL2):    prdata[7:0] <= {2'b00, ctrl2_r[5:0]};
          byte_addr(`ADC_IDX_RES_LOW):
            prdata[7:0] <= {result_r[1:0], done_flag_r, busy_r, 4'h0};
          byte_addr(`ADC_IDX_RES_HIGH): prdata[7:0] <= result_r[9:2];
          default:                      pslverr <= 1'b1;
        endcase
      end
    end
  end

  // helper: oscillator ticks seen during the running conversion
  logic [TW-1:0] tick_seen_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      tick_seen_r <= '0;
    else if (conv_go)
      tick_seen_r <= '0;
    else if (busy_r && fc_tick)
      tick_seen_r <= tick_seen_r + TW'(1);
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_start_sets_busy: assert property (start_req |=> busy_r && !ctrl1_r[`ADC_START_BIT])
    else $error("start did not raise busy and clear start");
  a_conv_length: assert property (conv_done |-> tick_seen_r == ticks_sel - TW'(1))
    else $error("conversion length differs from selected ticks");
  a_done_stores: assert property (conv_done && !standby_req && !mode_kill |=>
      done_flag_r && conversion_done_irq && result_r == $past(sar_r))
    else $error("completion did not store and flag together");
  a_high_read_clears: assert property (rd_acc && paddr == byte_addr(`ADC_IDX_RES_HIGH)
      && !conv_done |=> !done_flag_r)
    else $error("high result read left done flag set");
  a_mode_off_abort: assert property (mode_kill |=> !busy_r && $stable(result_r))
    else $error("mode off did not abort cleanly");
  a_standby_reset: assert property (standby_req |=> ctrl1_r == `ADC_CTRL1_RESET
      && ctrl2_r == `ADC_CTRL2_RESET && !busy_r)
    else $error("standby did not reset control state");
  a_ladder_follows: assert property (!ctrl2_r[`ADC_LADDER_BIT] && !busy_r ##1 1
      |-> !ladder_connect)
    else $error("ladder connected while idle and not forced");
  a_repeat_restart: assert property (restart |=> busy_r ##1 busy_r)
    else $error("repeat mode did not restart");
  a_restart_keeps: assert property (start_req && done_flag_r |=>
      !done_flag_r && $stable(result_r))
    else $error("new start lost old result or kept flag");

  c_soft_done: cover property (start_req && mode == adc_pkg::MODE_SOFT ##[1:800] conv_done);
  c_repeat_two: cover property (restart ##[1:800] conv_done);
  c_abort: cover property (busy_r ##1 mode_kill);
  c_standby_busy: cover property (busy_r && standby_req);
endmodule : sar_adc_ctrl

// ==== dv/adc_front_model.sv ====
// behavioural sample-hold, comparator and ladder facing the converter control
`timescale 1ns/1ns
module adc_front_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // analog levels of inputs 0 to 7, ten bits each
  input  wire logic [79:0] levels,
  // from the converter control
  input  wire logic [3:0]  channel_select_field,
  input  wire logic        analog_input_disable,
  input  wire logic        ladder_connect,
  input  wire logic        sample_hold,
  input  wire logic [9:0]  dac_code,
  // to the converter control
  output logic             comparator_in
);
  logic [9:0] held_r;
  logic       junk_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      held_r <= 10'h000;
      junk_r <= 1'b0;
    end else begin
      junk_r <= ~junk_r;
      // disabled or reserved inputs read as ground
      if (sample_hold) begin
        held_r <= (analog_input_disable || channel_select_field[3]) ? 10'h000
                  : levels[channel_select_field[2:0]*10 +: 10];
      end
    end
  end

  // no reference without the ladder, so the comparator only toggles
  assign comparator_in = ladder_connect ? (held_r >= dac_code) : junk_r;
endmodule : adc_front_model

// ==== dv/sar_adc_ctrl_tb.sv ====
// self-checking bench for the converter control
`timescale 1ns/1ns
`include "adc_cfg.svh"
module sar_adc_ctrl_tb;
  localparam int         FCD  = 4;
  localparam logic [7:0] A_C1 = `ADC_IDX_CTRL1 * 4;
  localparam logic [7:0] A_C2 = `ADC_IDX_CTRL2 * 4;
  localparam logic [7:0] A_RL = `ADC_IDX_RES_LOW * 4;
  localparam logic [7:0] A_RH = `ADC_IDX_RES_HIGH * 4;
  logic        clk_sys = 1'b0, rst_n = 1'b0, standby_req = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic        pready, pslverr, comparator_in, analog_input_disable;
  logic        ladder_connect, sample_hold, conversion_done_irq;
  logic [3:0]  channel_select_field;
  logic [9:0]  dac_code, last_r = 10'h000, lv;
  logic [79:0] levels = 80'h0;
  logic [32:0] expq[$];
  int          fails = 0, n_tests = 0, cyc = 0, t0 = 0, dt = 0, seed = 32'h2920166B;
  int          tk[8] = '{39, 39, 78, 156, 312, 624, 1248, 1248};

  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  sar_adc_ctrl #(.AW(8), .FC_DIV(FCD)) dut_u (.clk_sys, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .standby_req, .comparator_in,
    .channel_select_field, .analog_input_disable, .ladder_connect, .sample_hold, .dac_code,
    .conversion_done_irq);
  adc_front_model fe_u (.clk_sys, .rst_n, .levels, .channel_select_field,
    .analog_input_disable, .ladder_connect, .sample_hold, .dac_code, .comparator_in);

  task automatic wrap_up();
    if (fails == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk(pready, 1'b1, "no ready");
    if (pready !== 1'b1) wrap_up();
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back({9'h000, 16'h0000, e});
    bus(1'b0, a, 8'h00);
  endtask : rd

  // read results are matched in bus order as they appear
  always @(posedge clk_sys) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      if (expq.size() == 0) begin
        chk({pslverr, prdata}, 33'h1FFFFFFFF, "unexpected read");
      end else begin
        chk({pslverr, prdata}, expq.pop_front(), "read data");
      end
    end
  end

  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (conversion_done_irq !== 1'b1 && n < lim);
    chk(conversion_done_irq, 1'b1, "no completion");
    if (conversion_done_irq !== 1'b1) wrap_up();
  endtask : wait_irq

  task automatic quiet(input int n);
    int h;
    h = 0;
    repeat (n) begin
      @(posedge clk_sys);
      if (conversion_done_irq !== 1'b0) h++;
    end
    chk(h, 0, "stray completion");
  endtask : quiet

  task automatic soft_conv(input logic [2:0] code);
    logic [2:0] ch;
    ch = 3'($unsigned($random(seed)));
    lv = 10'($random(seed));
    levels[ch*10 +: 10] <= lv;
    bus(1'b1, A_C2, {2'b11, 2'b01, code, 1'b0});
    rd(A_C2, {2'b00, 2'b01, code, 1'b0});
    bus(1'b1, A_C1, {4'hA, 1'b0, ch});
    t0 = cyc;
    repeat (3) @(posedge clk_sys);
    chk(channel_select_field, {1'b0, ch}, "channel");
    chk(analog_input_disable, 1'b0, "input enable");
    chk(sample_hold, 1'b1, "sample phase");
    rd(A_C1, {4'h2, 1'b0, ch});
    rd(A_RL, {last_r[1:0], 2'b01, 4'h0});
    rd(A_RH, last_r[9:2]);
    chk(ladder_connect, 1'b1, "ladder in run");
    wait_irq(tk[code] * FCD + 20);
    // start lands two edges after the write; the oscillator phase moves the end by one tick
    dt = cyc - t0;
    chk(dt >= tk[code] * FCD - FCD + 3 && dt <= tk[code] * FCD + 2, 1'b1, "length");
    @(posedge clk_sys);
    chk(conversion_done_irq, 1'b0, "irq width");
    chk(dac_code, lv, "final trial");
    chk(sample_hold, 1'b0, "sample after done");
    rd(A_RL, {lv[1:0], 2'b10, 4'h0});
    chk(ladder_connect, 1'b0, "ladder idle");
    last_r = lv;
  endtask : soft_conv

  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(A_C1, 8'h10);
    rd(A_C2, 8'h00);
    rd(A_RL, 8'h00);
    rd(A_RH, 8'h00);
    expq.push_back({1'b1, 32'h00000000});
    bus(1'b0, 8'h80, 8'h00);
    chk(analog_input_disable, 1'b1, "input disable");
    for (int c = 0; c < 8; c++) soft_conv(3'(c));
    rd(A_RH, last_r[9:2]);
    rd(A_RL, {last_r[1:0], 2'b00, 4'h0});
    bus(1'b1, A_C2, 8'h30);
    repeat (3) @(posedge clk_sys);
    chk(ladder_connect, 1'b1, "ladder forced");
    // repeat mode on input 0, then stopped by mode off
    lv = 10'($random(seed));
    levels[9:0] <= lv;
    bus(1'b1, A_C2, 8'h10);
    bus(1'b1, A_C1, 8'hE0);
    wait_irq(200);
    t0 = cyc;
    wait_irq(200);
    chk(cyc - t0, 39 * FCD, "restart period");
    levels[9:0] <= ~lv;
    rd(A_RL, {lv[1:0], 2'b11, 4'h0});
    bus(1'b1, A_C1, 8'h00);
    rd(A_RL, {lv[1:0], 2'b10, 4'h0});
    rd(A_RH, lv[9:2]);
    quiet(200);
    // reserved mode leaves the start request pending and idle
    bus(1'b1, A_C1, 8'hC0);
    quiet(100);
    rd(A_C1, 8'hC0);
    // standby in the middle of a long conversion
    bus(1'b1, A_C2, 8'h3C);
    bus(1'b1, A_C1, 8'hA5);
    repeat (10) @(posedge clk_sys);
    standby_req <= 1'b1;
    bus(1'b1, A_C2, 8'h12);
    rd(A_C2, 8'h00);
    rd(A_C1, 8'h10);
    rd(A_RL, 8'h00);
    standby_req <= 1'b0;
    quiet(3000);
    rd(A_RL, 8'h00);
    chk(ladder_connect, 1'b0, "ladder after standby");
    wrap_up();
  end
endmodule : sar_adc_ctrl_tb
